// ==== irpw_pkg.sv ====
//==========================================================
// receiver constants
//==========================================================
package irpw_pkg;

	//==========================================================
	// register byte offsets on the apb slave
	//==========================================================
	localparam logic [7:0] OFS_CTRL      = 8'h00; // enable control
	localparam logic [7:0] OFS_SHIFT     = 8'h04; // rx_shift_byte
	localparam logic [7:0] OFS_DATA      = 8'h08; // rx_data_byte
	localparam logic [7:0] OFS_COUNT     = 8'h0c; // rx_bit_count
	localparam logic [7:0] OFS_GUIDE_MIN = 8'h10; // guide_high_min
	localparam logic [7:0] OFS_GUIDE_MAX = 8'h14; // guide_high_max
	localparam logic [7:0] OFS_LOW_MIN   = 8'h18; // data_low_min
	localparam logic [7:0] OFS_LOW_MAX   = 8'h1c; // data_low_max
	localparam logic [7:0] OFS_ZERO_MIN  = 8'h20; // zero_high_min
	localparam logic [7:0] OFS_ZERO_MAX  = 8'h24; // zero_high_max
	localparam logic [7:0] OFS_ONE_MIN   = 8'h28; // one_high_min
	localparam logic [7:0] OFS_STATUS    = 8'h2c; // receiver state

	//==========================================================
	// field positions and reset values
	//==========================================================
	localparam int         CTRL_EN_BIT   = 0;     // rx_enable_bit position
	localparam int         STAT_END_BIT  = 0;     // waiting for shift read
	localparam int         STAT_BUSY_BIT = 1;     // frame in progress
	localparam int         STAT_LVL_BIT  = 2;     // synchronised input level
	localparam logic [7:0] BYTE_RST      = 8'h00; // reset of all byte regs
	localparam logic [7:0] COUNT_WRAP    = 8'h07; // last partial count
	localparam logic [7:0] COUNT_ONE     = 8'h01; // count step
	localparam logic [7:0] WIDTH_SAT     = 8'hff; // width counter ceiling

	//==========================================================
	// timing: width counter tick derived from ref_clk
	//==========================================================
	localparam int         CLK_HZ        = 10_000_000; // ref_clk rate
	localparam int         TICK_HZ       = 1_000_000;  // width tick rate
	localparam logic [7:0] TICK_DIV      = 8'(CLK_HZ / TICK_HZ); // cycles per tick

	//==========================================================
	// receiver states, one-hot
	//==========================================================
	typedef enum logic [4:0]
	{
		ST_OFF     = 5'h01, // reception disabled
		ST_WAIT_HI = 5'h02, // waiting for guide rising edge
		ST_GUIDE   = 5'h04, // measuring guide high width
		ST_DATA_LO = 5'h08, // measuring data low width
		ST_DATA_HI = 5'h10  // measuring data high width
	} irpw_state_t;

endpackage : irpw_pkg

// ==== irpw_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
//==========================================================
// two-stage synchroniser for the remote control pin
//==========================================================
module irpw_sync2
	import irpw_pkg::*;
(
	input  wire logic ref_clk,  // receiver clock
	input  wire logic rst_n,    // async reset, active low
	input  wire logic pin_in,   // asynchronous pin level
	output logic      pin_sync  // level safe to use
);

	typedef struct packed
	{
		logic meta_r;  // first stage, read only by second
		logic sync_r;  // second stage
	} irpw_sync_t;

	irpw_sync_t s_r;   // registered state
	irpw_sync_t s_nxt; // next state

	// shift the pin through both stages
	always_comb
	begin
		s_nxt.meta_r = pin_in;
		s_nxt.sync_r = s_r.meta_r;
	end

	// state register
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign pin_sync = s_r.sync_r;

endmodule // irpw_sync2
`default_nettype wire

// ==== irpw_width_ctr.sv ====
`timescale 1ns/1ps
`default_nettype none
//==========================================================
// tick divider and saturating level-width counter
//==========================================================
module irpw_width_ctr
	import irpw_pkg::*;
(
	input  wire logic       ref_clk, // receiver clock
	input  wire logic       rst_n,   // async reset, active low
	input  wire logic       run,     // counting allowed
	input  wire logic       restart, // edge seen: width back to zero
	output logic [7:0]      width    // ticks since last restart
);

	typedef struct packed
	{
		logic [7:0] div_r;   // prescale counter
		logic [7:0] width_r; // measured width
	} irpw_wctr_t;

	irpw_wctr_t s_r;   // registered state
	irpw_wctr_t s_nxt; // next state
	logic       tick;  // one-cycle tick enable

	// divider makes the tick, width counts ticks and saturates
	always_comb
	begin
		s_nxt = s_r;
		tick  = (s_r.div_r == TICK_DIV - 8'h01);
		if (!run || restart)
		begin
			// level starts anew, align the tick to the edge
			s_nxt.div_r   = BYTE_RST;
			s_nxt.width_r = BYTE_RST;
		end
		else
		begin
			s_nxt.div_r = tick ? BYTE_RST : s_r.div_r + 8'h01;
			if (tick && s_r.width_r != WIDTH_SAT)
				s_nxt.width_r = s_r.width_r + 8'h01;
		end
	end

	// state register
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign width = s_r.width_r;

endmodule // irpw_width_ctr
`default_nettype wire

// ==== irpw_receiver.sv ====
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
//==========================================================
// pulse-width remote control receiver with apb registers
//==========================================================
// Function
// - new bit enters bit 7, shifts down
// - shift byte clears on reset, off, full and error events
// - eighth bit copies byte, pulses byte full
// - data byte: newest bit 7, oldest 0
// - data byte zero on reset or disable
// - new full byte overwrites unread data byte
// - bit count steps 1..7, wraps at eight
// - bit count clears on reset, off, error, read
// - guide high min and max compare registers
// - data low min and max compare registers
// - low accepted when min <= width < max
// - zero high min and max compare registers
// - one high min compare register
// - enable bit starts, clearing stops and clears
// - bad guide width discarded, wait next rise
// - short data low gives error, back to guide
// - long data low ends data, end measured
module irpw_receiver
	import irpw_pkg::*;
(
	input  wire logic        ref_clk,         // receiver clock, 10 MHz
	input  wire logic        rst_n,           // async reset, active low
	input  wire logic        psel,            // apb select
	input  wire logic        penable,         // apb access phase
	input  wire logic        pwrite,          // apb write when high
	input  wire logic [7:0]  paddr,           // apb byte address
	input  wire logic [31:0] pwdata,          // apb write data
	output logic [31:0]      prdata,          // apb read data
	output logic             pready,          // apb ready
	output logic             pslverr,         // apb error on unmapped address
	input  wire logic        rc_in,           // remote control input pin
	output logic             byte_full_event, // pulse: byte moved to data
	output logic             rx_error_event,  // pulse: width error
	output logic             rx_end_event     // pulse: end of reception
);

	//==========================================================
	// state
	//==========================================================
	typedef struct packed
	{
		irpw_state_t st_r;        // receiver state
		logic        en_r;        // rx_enable_bit
		logic        end_r;       // frame ended, waiting for shift read
		logic        lvl_r;       // previous input level for edges
		logic [7:0]  shift_r;     // rx_shift_byte
		logic [7:0]  data_r;      // rx_data_byte
		logic [7:0]  count_r;     // rx_bit_count
		logic [7:0]  g_min_r;     // guide_high_min
		logic [7:0]  g_max_r;     // guide_high_max
		logic [7:0]  l_min_r;     // data_low_min
		logic [7:0]  l_max_r;     // data_low_max
		logic [7:0]  z_min_r;     // zero_high_min
		logic [7:0]  z_max_r;     // zero_high_max
		logic [7:0]  o_min_r;     // one_high_min
		logic [31:0] prdata_r;    // read data
		logic        pready_r;    // ready in access phase
		logic        pslverr_r;   // error answer
		logic        full_r;      // byte full pulse
		logic        err_r;       // error pulse
		logic        rend_r;      // end pulse
	} irpw_regs_t;

	irpw_regs_t  s_r;        // registered state
	irpw_regs_t  s_nxt;      // next state
	logic        lvl;        // synchronised input level
	logic [7:0]  width;      // current level width in ticks
	logic        rise;       // rising edge of input
	logic        fall;       // falling edge of input
	logic        meas_run;   // width counter running
	logic        setup;      // apb setup cycle
	logic        done;       // apb transfer completes this edge
	logic        mapped;     // address decodes to a register
	logic [7:0]  rd_byte;    // selected register value
	logic        bit_ok;     // a data bit was decoded
	logic        bit_val;    // decoded bit value
	logic        go_err;     // error event this cycle
	logic [7:0]  shifted;    // shift byte with new bit

	//==========================================================
	// pin synchroniser and width counter
	//==========================================================
	irpw_sync2 u_sync
	(
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.pin_in   (rc_in),
		.pin_sync (lvl)
	);

	irpw_width_ctr u_width
	(
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.run     (meas_run),
		.restart (rise || fall),
		.width   (width)
	);

	//==========================================================
	// edge detect and bus decode
	//==========================================================
	// edges compare the settled level with its last value
	always_comb
	begin
		rise     = lvl && !s_r.lvl_r;
		fall     = !lvl && s_r.lvl_r;
		meas_run = s_r.en_r && !s_r.end_r;
		setup    = psel && !penable;
		done     = psel && penable && s_r.pready_r;
		shifted  = {bit_val, s_r.shift_r[7:1]};
	end

	// register read mux, narrow registers in the low byte
	always_comb
	begin
		mapped  = 1'b1;
		rd_byte = BYTE_RST;
		case (paddr)
			OFS_CTRL:      rd_byte[CTRL_EN_BIT] = s_r.en_r;
			OFS_SHIFT:     rd_byte = s_r.shift_r;
			OFS_DATA:      rd_byte = s_r.data_r;
			OFS_COUNT:     rd_byte = s_r.count_r;
			OFS_GUIDE_MIN: rd_byte = s_r.g_min_r;
			OFS_GUIDE_MAX: rd_byte = s_r.g_max_r;
			OFS_LOW_MIN:   rd_byte = s_r.l_min_r;
			OFS_LOW_MAX:   rd_byte = s_r.l_max_r;
			OFS_ZERO_MIN:  rd_byte = s_r.z_min_r;
			OFS_ZERO_MAX:  rd_byte = s_r.z_max_r;
			OFS_ONE_MIN:   rd_byte = s_r.o_min_r;
			OFS_STATUS:
			begin
				rd_byte[STAT_END_BIT]  = s_r.end_r;
				rd_byte[STAT_BUSY_BIT] = !(s_r.st_r inside {ST_OFF, ST_WAIT_HI});
				rd_byte[STAT_LVL_BIT]  = s_r.lvl_r;
			end
			default:       mapped = 1'b0;
		endcase
	end

	//==========================================================
	// data high classification
	//==========================================================
	always_comb
	begin
		bit_ok  = 1'b0;
		bit_val = 1'b0;
		go_err  = 1'b0;
		if (s_r.st_r == ST_DATA_HI && fall)
		begin
			if (width >= s_r.z_min_r && width < s_r.z_max_r)
			begin
				// within zero window
				bit_ok  = 1'b1;
				bit_val = 1'b0;
			end
			else if (width >= s_r.o_min_r && width >= s_r.z_max_r)
			begin
				// at or above one lower bound
				bit_ok  = 1'b1;
				bit_val = 1'b1;
			end
			else
				go_err = 1'b1; // fits neither window
		end
		// short low error, none while an end is pending
		// the counter is stopped then, so a rise would read width zero
		if (s_r.st_r == ST_DATA_LO && !s_r.end_r && rise && width < s_r.l_min_r)
			go_err = 1'b1;
	end

	//==========================================================
	// next state
	//==========================================================
	always_comb
	begin
		s_nxt          = s_r;
		s_nxt.lvl_r    = lvl;
		s_nxt.full_r   = 1'b0;
		s_nxt.err_r    = 1'b0;
		s_nxt.rend_r   = 1'b0;
		s_nxt.pready_r = 1'b0;
		s_nxt.pslverr_r = 1'b0; // error answer stands with ready only

		// apb setup: latch answer so outputs come from flops
		if (setup)
		begin
			s_nxt.pready_r  = 1'b1;
			s_nxt.pslverr_r = !mapped;
			s_nxt.prdata_r  = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
		end

		// receiver sequence
		case (s_r.st_r)
			ST_OFF:
				if (s_r.en_r)
					s_nxt.st_r = ST_WAIT_HI;
			ST_WAIT_HI:
				if (rise)
					s_nxt.st_r = ST_GUIDE;
			ST_GUIDE:
				if (fall)
				begin
					if (width >= s_r.g_min_r && width < s_r.g_max_r)
						s_nxt.st_r = ST_DATA_LO;
					else
						s_nxt.st_r = ST_WAIT_HI;
				end
			ST_DATA_LO:
				if (!s_r.end_r)
				begin
					if (!lvl && width >= s_r.l_max_r)
					begin
						s_nxt.end_r  = 1'b1;
						s_nxt.rend_r = 1'b1;
					end
					else if (rise && width >= s_r.l_min_r)
						s_nxt.st_r = ST_DATA_HI;
					else if (go_err)
						s_nxt.st_r = ST_WAIT_HI;
				end
			ST_DATA_HI:
				if (bit_ok)
					s_nxt.st_r = ST_DATA_LO;
				else if (go_err)
					s_nxt.st_r = ST_WAIT_HI;
			default:
				s_nxt.st_r = ST_OFF;
		endcase

		// decoded bit into shift byte and count
		if (bit_ok)
		begin
			if (s_r.count_r == COUNT_WRAP)
			begin
				// oldest bit at 0, newest at 7
				s_nxt.data_r  = shifted;
				s_nxt.full_r  = 1'b1;
				s_nxt.count_r = BYTE_RST;
				s_nxt.shift_r = BYTE_RST;
			end
			else
			begin
				s_nxt.shift_r = shifted;
				s_nxt.count_r = s_r.count_r + COUNT_ONE;
			end
		end

		if (go_err)
		begin
			s_nxt.err_r   = 1'b1;
			s_nxt.shift_r = BYTE_RST;
			s_nxt.count_r = BYTE_RST;
		end

		// apb access completes: writes and read side effects
		if (done && !s_r.pslverr_r)
		begin
			if (pwrite)
			begin
				case (paddr)
					OFS_CTRL:      s_nxt.en_r    = pwdata[CTRL_EN_BIT];
					OFS_GUIDE_MIN: s_nxt.g_min_r = pwdata[7:0];
					OFS_GUIDE_MAX: s_nxt.g_max_r = pwdata[7:0];
					OFS_LOW_MIN:   s_nxt.l_min_r = pwdata[7:0];
					OFS_LOW_MAX:   s_nxt.l_max_r = pwdata[7:0];
					OFS_ZERO_MIN:  s_nxt.z_min_r = pwdata[7:0];
					OFS_ZERO_MAX:  s_nxt.z_max_r = pwdata[7:0];
					OFS_ONE_MIN:   s_nxt.o_min_r = pwdata[7:0];
					default:       s_nxt.en_r    = s_r.en_r; // read-only targets
				endcase
			end
			else if (paddr == OFS_SHIFT && s_r.end_r)
			begin
				s_nxt.shift_r = BYTE_RST;
				s_nxt.count_r = BYTE_RST;
				s_nxt.end_r   = 1'b0;
				s_nxt.st_r    = ST_WAIT_HI;
			end
		end

		if (!s_r.en_r)
		begin
			s_nxt.st_r    = ST_OFF;
			s_nxt.end_r   = 1'b0;
			s_nxt.shift_r = BYTE_RST;
			s_nxt.count_r = BYTE_RST;
			s_nxt.data_r  = BYTE_RST;
		end
	end

	//==========================================================
	// state register
	//==========================================================
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_r      <= '0;
			s_r.st_r <= ST_OFF;
		end
		else
			s_r <= s_nxt;
	end

	//==========================================================
	// outputs, all from flops
	//==========================================================
	assign prdata          = s_r.prdata_r;
	assign pready          = s_r.pready_r;
	assign pslverr         = s_r.pslverr_r;
	assign byte_full_event = s_r.full_r;
	assign rx_error_event  = s_r.err_r;
	assign rx_end_event    = s_r.rend_r;

endmodule // irpw_receiver
`default_nettype wire

// ==== irpw_rc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
//==========================================================
// remote pin driver, levels in microsecond steps
//==========================================================
module irpw_rc_model
(
	input  wire logic ref_clk, // receiver clock
	output var logic  rc       // pin level, idle low
);
	// hold one level for us microseconds of ten clocks
	task automatic lvl(input logic v, input int us);
		@(posedge ref_clk) rc <= v;
		repeat (us * 10 - 1) @(posedge ref_clk);
	endtask

	// guide high, n bits oldest first, then a long low ends it
	task automatic frame(input logic [15:0] v, input int n);
		lvl(1'b1, 9);
		for (int i = 0; i < n; i++)
		begin
			lvl(1'b0, 5);
			lvl(1'b1, v[i] ? 8 : 3);
		end
		lvl(1'b0, 25);
	endtask

	// pin idles low so every frame opens with a clean rise
	initial rc = 1'b0;
endmodule // irpw_rc_model
`default_nettype wire

// ==== irpw_receiver_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
//==========================================================
// port checker for the receiver
//==========================================================
module irpw_receiver_assertions
	import irpw_pkg::*;
(
	input wire logic        ref_clk,         // receiver clock
	input wire logic        rst_n,           // async reset, active low
	input wire logic        psel,            // apb select
	input wire logic        penable,         // apb access phase
	input wire logic        pwrite,          // apb direction
	input wire logic [7:0]  paddr,           // apb address
	input wire logic [31:0] pwdata,          // apb write data
	input wire logic [31:0] prdata,          // apb read data
	input wire logic        pready,          // apb ready
	input wire logic        pslverr,         // apb error
	input wire logic        rc_in,           // remote pin
	input wire logic        byte_full_event, // byte moved
	input wire logic        rx_error_event,  // width error
	input wire logic        rx_end_event     // end of reception
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// apb phases
	sequence s_setup; psel && !penable; endsequence
	sequence s_access; psel && penable && pready; endsequence

	property p_ready; s_setup |=> s_access; endproperty
	property p_rdy_once; pready |=> !pready; endproperty
	property p_unmapped; pready && paddr > OFS_STATUS |-> pslverr; endproperty
	property p_mapped; pready && paddr[1:0] == 2'h0 && paddr <= OFS_STATUS |-> !pslverr; endproperty
	property p_err_gated; pslverr |-> pready; endproperty
	property p_wr_zero; pready && pwrite |-> prdata == 32'h00000000; endproperty
	property p_upper; pready |-> prdata[31:8] == 24'h000000; endproperty
	property p_full_pulse; byte_full_event |=> !byte_full_event; endproperty
	property p_full_high; byte_full_event |-> $past(rc_in, 5); endproperty
	property p_err_pulse; rx_error_event |=> !rx_error_event; endproperty
	property p_end_low; rx_end_event |-> !$past(rc_in, 4); endproperty
	property p_excl; !(byte_full_event && rx_error_event); endproperty

	a_ready: assert property (p_ready) else $error("no ready after setup");
	a_rdy_once: assert property (p_rdy_once) else $error("ready longer than one cycle");
	a_unmapped: assert property (p_unmapped) else $error("unmapped address without error");
	a_mapped: assert property (p_mapped) else $error("error on mapped address");
	a_err_gated: assert property (p_err_gated) else $error("error without ready");
	a_wr_zero: assert property (p_wr_zero) else $error("read data on write");
	a_upper: assert property (p_upper) else $error("upper read bits set");
	a_full_pulse: assert property (p_full_pulse) else $error("byte full too long");
	a_full_high: assert property (p_full_high) else $error("byte full not after high");
	a_err_pulse: assert property (p_err_pulse) else $error("error event too long");
	a_end_low: assert property (p_end_low) else $error("end event while input high");
	a_excl: assert property (p_excl) else $error("byte full with error");
endmodule // irpw_receiver_assertions

bind irpw_receiver irpw_receiver_assertions chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .rc_in(rc_in), .byte_full_event(byte_full_event), .rx_error_event(rx_error_event),
	.rx_end_event(rx_end_event));
`default_nettype wire

// ==== irpw_receiver_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
//==========================================================
// self-checking bench over apb and the remote pin
//==========================================================
module irpw_receiver_bench;
	import irpw_pkg::*;
	localparam logic [7:0] CA [7] = '{OFS_GUIDE_MIN, OFS_GUIDE_MAX, OFS_LOW_MIN, OFS_LOW_MAX,
		OFS_ZERO_MIN, OFS_ZERO_MAX, OFS_ONE_MIN}; // compare offsets
	localparam logic [7:0] CV [7] = '{8'h05, 8'h0c, 8'h03, 8'h14, 8'h02, 8'h04, 8'h06}; // windows in us
	logic        ref_clk, rst_n, psel, penable, pwrite; // bench driven
	logic [7:0]  paddr, q;                              // address, read byte
	logic [31:0] pwdata, prdata;                        // apb data
	logic        pready, pslverr, rc, e;                // answers, pin
	logic        byte_full_event, rx_error_event, rx_end_event; // events
	int          fails, n_tests, n_full, n_err, n_end;  // counters

	irpw_receiver dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rc_in(rc), .byte_full_event(byte_full_event),
		.rx_error_event(rx_error_event), .rx_end_event(rx_end_event));
	irpw_rc_model rc_u (.ref_clk(ref_clk), .rc(rc));

	// clock of 100 ns
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// count event pulses
	always @(posedge ref_clk)
	begin
		if (byte_full_event === 1'b1) n_full++;
		if (rx_error_event === 1'b1) n_err++;
		if (rx_end_event === 1'b1) n_end++;
	end

	// one apb transfer; read byte and error land in q and e
	task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge ref_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, 24'h000000, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		q = prdata[7:0];
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask

	// byte compare
	task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] s);
		n_tests++;
		if (s !== x)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, x, s);
		end
	endtask

	// event count compare
	task automatic chkn(input string nm, input int x, input int s);
		n_tests++;
		if (s != x)
		begin
			fails++;
			$display("mismatch %s expected %0d seen %0d", nm, x, s);
		end
	endtask

	// verdict and end of run
	task automatic stop_test();
		$display("errors %0d in %0d checks", fails, n_tests);
		if (fails == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// watchdog well beyond the half millisecond of traffic
	initial
	begin
		#3_000_000;
		fails++;
		stop_test();
	end

	// main sequence
	initial
	begin
		{rst_n, psel, penable, pwrite, paddr, pwdata, q, e} = '0;
		{fails, n_tests, n_full, n_err, n_end} = '0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 12; i++)
		begin
			apb(8'(4 * i), 1'b0, 8'h00);
			chk("reset value", 8'h00, q);
		end
		apb(8'h40, 1'b0, 8'h00);
		chk("unmapped error", 8'h01, {7'h00, e});
		for (int i = 0; i < 7; i++) apb(CA[i], 1'b1, CV[i]);
		for (int i = 0; i < 7; i++)
		begin
			apb(CA[i], 1'b0, 8'h00);
			chk("compare reg", CV[i], q);
		end
		apb(OFS_CTRL, 1'b1, 8'h01);
		// eleven bits: one byte and three left over
		rc_u.frame(16'h0535, 11);
		apb(OFS_COUNT, 1'b0, 8'h00);
		chk("partial count", 8'h03, q);
		apb(OFS_STATUS, 1'b0, 8'h00);
		chk("status at end", 8'h03, q);
		// a new guide while the end is pending is refused
		rc_u.lvl(1'b1, 9);
		rc_u.lvl(1'b0, 5);
		chkn("errors while pending", 0, n_err);
		apb(OFS_SHIFT, 1'b0, 8'h00);
		chk("partial shift", 8'ha0, q);
		apb(OFS_DATA, 1'b0, 8'h00);
		chk("first byte", 8'h35, q);
		apb(OFS_COUNT, 1'b0, 8'h00);
		chk("count after read", 8'h00, q);
		apb(OFS_SHIFT, 1'b0, 8'h00);
		chk("shift after read", 8'h00, q);
		chkn("full events", 1, n_full);
		chkn("end events", 1, n_end);
		// sixteen bits: second byte overwrites the first
		rc_u.frame(16'hc3a5, 16);
		apb(OFS_COUNT, 1'b0, 8'h00);
		chk("wrapped count", 8'h00, q);
		apb(OFS_SHIFT, 1'b0, 8'h00);
		chk("shift after full", 8'h00, q);
		apb(OFS_DATA, 1'b0, 8'h00);
		chk("overwritten byte", 8'hc3, q);
		chkn("full events", 3, n_full);
		// one bit, then a data low too short
		rc_u.lvl(1'b1, 9);
		rc_u.lvl(1'b0, 5);
		rc_u.lvl(1'b1, 8);
		rc_u.lvl(1'b0, 1);
		rc_u.lvl(1'b1, 3);
		rc_u.lvl(1'b0, 10);
		chkn("error events", 1, n_err);
		apb(OFS_COUNT, 1'b0, 8'h00);
		chk("count after error", 8'h00, q);
		apb(OFS_SHIFT, 1'b0, 8'h00);
		chk("shift after error", 8'h00, q);
		// guide too short, then too long: both dropped
		rc_u.lvl(1'b1, 2);
		rc_u.lvl(1'b0, 10);
		rc_u.lvl(1'b1, 15);
		rc_u.lvl(1'b0, 10);
		apb(OFS_COUNT, 1'b0, 8'h00);
		chk("count after bad guide", 8'h00, q);
		chkn("events after bad guide", 6, n_full + n_err + n_end);
		apb(OFS_CTRL, 1'b1, 8'h00);
		apb(OFS_DATA, 1'b0, 8'h00);
		chk("data when off", 8'h00, q);
		stop_test();
	end
endmodule // irpw_receiver_bench
`default_nettype wire
